// ### hdl/compressor_remote_io_control.sv
// Purpose: run/stop control, status contacts, lamps and running hours
// Assumes: APB master; pins already translated to logic levels (true = 1)
// Notes:   one wait state on every APB access; outputs all registered
//          pin pulses shorter than the filter time may go unseen

// Behaviour
// - remote start rising edge starts compressor
// - remote stop rising edge stops compressor
// - inhibit level keeps compressor stopped
// - level mode: start level-sensitive, stop ignored
// - inputs held 200 ms always recognised
// - rising false-to-true, falling true-to-false
// - open or negative input reads false
// - all-ok only when no error, warning, power
// - errors latch; cleared by reset or start, temp and pressure also by stop
// - warnings clear themselves when condition ends
// - running contact closed only while running
// - over-temperature contact latches, clears on event
// - over-pressure contact latches, clears on event
// - screen start equals button, main screen only
// - screen stop equals button, main screen only
// - on lamp lit while compressor operates
// - off lamp after stop button or trip
// - running hours count only while operating
module compressor_remote_io_control
	import remote_io_pkg::*;
#(
	parameter int unsigned FILTER     = remote_io_pkg::FILTER_CYCLES,
	parameter int unsigned SEC_CYCLES = remote_io_pkg::SECOND_CYCLES
) (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic [remote_io_pkg::ADDR_W-1:0] paddr,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [31:0]                 pwdata,
	output logic [31:0]                      prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic                        remote_start_in,
	input  wire logic                        remote_stop_in,
	input  wire logic                        remote_inhibit_in,
	input  wire logic                        level_mode_select_in,
	input  wire logic                        mech_start_btn,
	input  wire logic                        mech_stop_btn,
	input  wire logic                        panel_reset_btn,
	input  wire logic                        he_temp_high,
	input  wire logic                        he_pressure_high,
	input  wire logic                        fault_in,
	input  wire logic                        warning_in,
	input  wire logic                        line_power_ok,
	input  wire logic                        safety_trip_in,
	output logic                             compressor_run,
	output logic                             running_contact,
	output logic                             all_ok_contact,
	output logic                             over_temp_contact,
	output logic                             over_pressure_contact,
	output logic                             on_lamp,
	output logic                             off_lamp,
	output logic                             irq
);
	import remote_io_pkg::*;

	typedef struct packed {
		logic                 run;
		logic                 stopped_btn;
		logic                 temp_err;
		logic                 press_err;
		logic                 fault_err;
		logic                 main_screen;
		logic                 scr_start;
		logic                 scr_stop;
		logic                 warn_prev;
		logic                 err_prev;
		logic                 inhibit_prev;
		logic [IRQ_W-1:0]     irq_stat;
		logic [IRQ_W-1:0]     irq_en;
		logic [SEC_DIV_W-1:0] sec_div;
		logic [11:0]          sec_in_hr;
		logic [31:0]          hours;
		logic                 pready;
		logic                 pslverr;
		logic [31:0]          prdata;
		logic                 running_c;
		logic                 all_ok_c;
		logic                 temp_c;
		logic                 press_c;
		logic                 on_l;
		logic                 off_l;
		logic                 irq;
	} state_type;

	state_type s_q;
	state_type s_d;

	cond_if cif ();

	logic [NUM_IN-1:0] pin_vec;

	// pins placed by slot number, so a reordered slot table cannot swap two inputs
	always_comb begin
		pin_vec                 = '0;
		pin_vec[IN_START]       = remote_start_in;
		pin_vec[IN_STOP]        = remote_stop_in;
		pin_vec[IN_INHIBIT]     = remote_inhibit_in;
		pin_vec[IN_LEVEL]       = level_mode_select_in;
		pin_vec[IN_MECH_START]  = mech_start_btn;
		pin_vec[IN_MECH_STOP]   = mech_stop_btn;
		pin_vec[IN_PANEL_RESET] = panel_reset_btn;
		pin_vec[IN_TEMP_HIGH]   = he_temp_high;
		pin_vec[IN_PRESS_HIGH]  = he_pressure_high;
		pin_vec[IN_FAULT]       = fault_in;
		pin_vec[IN_WARNING]     = warning_in;
		pin_vec[IN_POWER_OK]    = line_power_ok;
		pin_vec[IN_SAFETY_TRIP] = safety_trip_in;
	end

	input_conditioner #(
		.FILTER (FILTER)
	) u_cond (
		.pclk    (pclk),
		.presetn (presetn),
		.pins    (pin_vec),
		.cif     (cif)
	);

	function automatic logic addr_known(input logic [ADDR_W-1:0] a);
		case (a)
			CONTROL_OFS, COMMAND_OFS, STATUS_OFS, IRQ_STATUS_OFS,
			IRQ_CLEAR_OFS, IRQ_ENABLE_OFS, HOURS_OFS, SECONDS_OFS:
				addr_known = 1'b1;
			default:
				addr_known = 1'b0;
		endcase
	endfunction

	logic level_mode;
	logic inhibit;
	logic start_req;
	logic stop_btn;
	logic stop_req;
	logic reset_btn;
	logic blocked;
	logic any_err;
	logic warn;
	logic power_ok;
	logic trip;
	logic apb_setup_done;
	logic apb_commit;
	logic [IRQ_W-1:0] irq_events;
	logic [31:0] status_word;

	always_comb begin
		s_d = s_q;

		level_mode = cif.level[IN_LEVEL];
		inhibit    = cif.level[IN_INHIBIT];
		warn       = cif.level[IN_WARNING];
		power_ok   = cif.level[IN_POWER_OK];
		trip       = cif.level[IN_SAFETY_TRIP];
		reset_btn  = cif.rise[IN_PANEL_RESET];

		// screen buttons arrive as one-cycle pulses from the command register
		s_d.scr_start = 1'b0;
		s_d.scr_stop  = 1'b0;

		start_req = cif.rise[IN_START] | cif.rise[IN_MECH_START] | s_q.scr_start;
		stop_btn  = cif.rise[IN_MECH_STOP] | s_q.scr_stop;
		stop_req  = stop_btn | (~level_mode & cif.rise[IN_STOP]);
		stop_req  = stop_req | (level_mode & cif.fall[IN_START]);

		if ((start_req | stop_req | reset_btn) & ~cif.level[IN_TEMP_HIGH]) begin
			s_d.temp_err = 1'b0;
		end
		if (cif.level[IN_TEMP_HIGH]) begin
			s_d.temp_err = 1'b1;
		end
		if ((start_req | stop_req | reset_btn) & ~cif.level[IN_PRESS_HIGH]) begin
			s_d.press_err = 1'b0;
		end
		if (cif.level[IN_PRESS_HIGH]) begin
			s_d.press_err = 1'b1;
		end
		if (start_req | reset_btn) begin
			s_d.fault_err = 1'b0;
		end
		if (cif.level[IN_FAULT]) begin
			s_d.fault_err = 1'b1;
		end
		any_err = s_d.temp_err | s_d.press_err | s_d.fault_err;

		blocked = inhibit | any_err | trip | ~power_ok
		        | (level_mode & ~cif.level[IN_START]);
		if (start_req) begin
			s_d.run = 1'b1;
		end
		if (stop_req | blocked) begin
			s_d.run = 1'b0;
		end

		if (start_req & s_d.run) begin
			s_d.stopped_btn = 1'b0;
		end
		if (stop_btn) begin
			s_d.stopped_btn = 1'b1;
		end

		// partial seconds survive a stop, so short runs still add up
		// hours only while running
		if (s_q.run) begin
			if (s_q.sec_div >= SEC_DIV_W'(SEC_CYCLES - 1)) begin
				s_d.sec_div = '0;
				if (s_q.sec_in_hr >= SECONDS_PER_HR - 12'h001) begin
					s_d.sec_in_hr = '0;
					s_d.hours     = s_q.hours + 32'h0000_0001;
				end else begin
					s_d.sec_in_hr = s_q.sec_in_hr + 12'h001;
				end
			end else begin
				s_d.sec_div = s_q.sec_div + SEC_DIV_W'(1);
			end
		end

		// interrupt events
		irq_events              = '0;
		irq_events[IRQ_START]   = s_d.run & ~s_q.run;
		irq_events[IRQ_STOP]    = s_q.run & ~s_d.run;
		irq_events[IRQ_ERROR]   = any_err & ~s_q.err_prev;
		irq_events[IRQ_WARNING] = warn & ~s_q.warn_prev;
		irq_events[IRQ_INHIBIT] = inhibit & ~s_q.inhibit_prev;
		s_d.err_prev     = any_err;
		s_d.warn_prev    = warn;
		s_d.inhibit_prev = inhibit;

		status_word     = '0;
		status_word[0]  = s_q.run;
		status_word[1]  = s_q.all_ok_c;
		status_word[2]  = s_q.temp_err;
		status_word[3]  = s_q.press_err;
		status_word[4]  = s_q.fault_err;
		status_word[5]  = warn;
		status_word[6]  = inhibit;
		status_word[7]  = level_mode;
		status_word[8]  = s_q.off_l;
		status_word[9]  = power_ok;
		status_word[10] = trip;

		// APB: setup, one wait cycle, then the completing cycle
		// the registered answer costs a wait state but keeps the decode off prdata
		apb_setup_done = psel & penable & ~s_q.pready;
		apb_commit     = psel & penable & s_q.pready;
		s_d.pready     = apb_setup_done;
		if (apb_setup_done) begin
			s_d.pslverr = ~addr_known(paddr);
			s_d.prdata  = '0;
			if (!pwrite) begin
				case (paddr)
					CONTROL_OFS:    s_d.prdata = {31'h0000_0000, s_q.main_screen};
					STATUS_OFS:     s_d.prdata = status_word;
					IRQ_STATUS_OFS: s_d.prdata = {{(32-IRQ_W){1'b0}}, s_q.irq_stat};
					IRQ_ENABLE_OFS: s_d.prdata = {{(32-IRQ_W){1'b0}}, s_q.irq_en};
					HOURS_OFS:      s_d.prdata = s_q.hours;
					SECONDS_OFS:    s_d.prdata = {20'h0_0000, s_q.sec_in_hr};
					default:        s_d.prdata = '0;
				endcase
			end
		end else if (apb_commit) begin
			s_d.pslverr = 1'b0;
			s_d.prdata  = '0;
		end

		// sticky bits: set by event wins over a clear in the same cycle
		if (apb_commit && pwrite && paddr == IRQ_CLEAR_OFS) begin
			s_d.irq_stat = s_q.irq_stat & ~pwdata[IRQ_W-1:0];
		end
		s_d.irq_stat = s_d.irq_stat | irq_events;

		if (apb_commit && pwrite) begin
			case (paddr)
				CONTROL_OFS: begin
					s_d.main_screen = pwdata[CTRL_MAIN_SCREEN];
				end
				COMMAND_OFS: begin
					s_d.scr_start = pwdata[CMD_SCR_START] & s_q.main_screen;
					s_d.scr_stop  = pwdata[CMD_SCR_STOP] & s_q.main_screen;
				end
				IRQ_ENABLE_OFS: begin
					s_d.irq_en = pwdata[IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end

		s_d.running_c = s_d.run;
		s_d.all_ok_c  = power_ok & ~any_err & ~warn & ~trip;
		// latched error contacts
		s_d.temp_c    = s_d.temp_err;
		s_d.press_c   = s_d.press_err;
		s_d.on_l      = s_d.run;
		s_d.off_l     = (s_d.stopped_btn & ~s_d.run) | trip;
		s_d.irq       = |(s_d.irq_stat & s_d.irq_en);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q             <= '0;
			s_q.main_screen <= CONTROL_RST[CTRL_MAIN_SCREEN];
			s_q.irq_en      <= IRQ_ENABLE_RST[IRQ_W-1:0];
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata                = s_q.prdata;
	assign pready                = s_q.pready;
	assign pslverr               = s_q.pslverr;
	assign compressor_run        = s_q.run;
	assign running_contact       = s_q.running_c;
	assign all_ok_contact        = s_q.all_ok_c;
	assign over_temp_contact     = s_q.temp_c;
	assign over_pressure_contact = s_q.press_c;
	assign on_lamp               = s_q.on_l;
	assign off_lamp              = s_q.off_l;
	assign irq                   = s_q.irq;

endmodule

// ### hdl/cond_if.sv
// Purpose: carries conditioned pin levels and edge pulses between modules
// Assumes: all signals on pclk
// Notes:   rise and fall are one-cycle pulses
interface cond_if;
	import remote_io_pkg::*;
	logic [NUM_IN-1:0] level;
	logic [NUM_IN-1:0] rise;
	logic [NUM_IN-1:0] fall;
	modport producer (output level, output rise, output fall);
	modport consumer (input level, input rise, input fall);
endinterface

// ### hdl/input_conditioner.sv
// Purpose: two-stage synchroniser, glitch filter and edge detect per pin
// Assumes: pins are asynchronous to pclk; a released or open pin reads 0
// Notes:   filter is far shorter than the guaranteed pulse width
module input_conditioner
	import remote_io_pkg::*;
#(
	parameter int unsigned FILTER = remote_io_pkg::FILTER_CYCLES
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic [remote_io_pkg::NUM_IN-1:0] pins,
	cond_if.producer               cif
);
	import remote_io_pkg::*;

	localparam int unsigned CW = $clog2(FILTER + 1);

	typedef struct packed {
		logic [NUM_IN-1:0]         meta;
		logic [NUM_IN-1:0]         sync;
		logic [NUM_IN-1:0]         stable;
		logic [NUM_IN-1:0][CW-1:0] cnt;
		logic [NUM_IN-1:0]         rise;
		logic [NUM_IN-1:0]         fall;
	} cond_state_type;

	cond_state_type c_q;
	cond_state_type c_d;

	always_comb begin
		c_d = c_q;
		c_d.meta = pins;
		c_d.sync = c_q.meta;
		c_d.rise = '0;
		c_d.fall = '0;
		for (int i = 0; i < NUM_IN; i++) begin
			if (c_q.sync[i] == c_q.stable[i]) begin
				c_d.cnt[i] = '0;
			end else if (c_q.cnt[i] >= CW'(FILTER - 1)) begin
				c_d.cnt[i]    = '0;
				c_d.stable[i] = c_q.sync[i];
				c_d.rise[i]   = c_q.sync[i];
				c_d.fall[i]   = ~c_q.sync[i];
			end else begin
				c_d.cnt[i] = c_q.cnt[i] + CW'(1);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			c_q <= '0;
		end else begin
			c_q <= c_d;
		end
	end

	assign cif.level = c_q.stable;
	assign cif.rise  = c_q.rise;
	assign cif.fall  = c_q.fall;

endmodule

// ### hdl/remote_io_pkg.sv
// Purpose: shared constants of the compressor remote I/O block
// Assumes: 125 MHz pclk, APB register access with 32-bit data
// Notes:   input slot numbers index the conditioned pin vectors
package remote_io_pkg;

	localparam int unsigned CLK_HZ         = 125_000_000;
	localparam int unsigned CLK_MHZ        = CLK_HZ / 1_000_000;

	// glitch filter; a longest time, so the cycle count rounds down
	localparam int unsigned FILTER_TIME_US = 10_000;
	localparam int unsigned FILTER_CYCLES  = CLK_MHZ * FILTER_TIME_US;
	// pulses that the remote controller holds for at least this long are always seen
	localparam int unsigned MIN_PULSE_MS   = 200;

	localparam int unsigned SECOND_CYCLES  = CLK_HZ;
	localparam int unsigned SEC_DIV_W      = 27;
	localparam logic [11:0] SECONDS_PER_HR = 12'hE10;

	// conditioned input slots
	localparam int unsigned IN_START       = 0;
	localparam int unsigned IN_STOP        = 1;
	localparam int unsigned IN_INHIBIT     = 2;
	localparam int unsigned IN_LEVEL       = 3;
	localparam int unsigned IN_MECH_START  = 4;
	localparam int unsigned IN_MECH_STOP   = 5;
	localparam int unsigned IN_PANEL_RESET = 6;
	localparam int unsigned IN_TEMP_HIGH   = 7;
	localparam int unsigned IN_PRESS_HIGH  = 8;
	localparam int unsigned IN_FAULT       = 9;
	localparam int unsigned IN_WARNING     = 10;
	localparam int unsigned IN_POWER_OK    = 11;
	localparam int unsigned IN_SAFETY_TRIP = 12;
	localparam int unsigned NUM_IN         = 13;

	// register byte offsets
	localparam int unsigned ADDR_W         = 8;
	localparam logic [7:0]  CONTROL_OFS    = 8'h00;
	localparam logic [7:0]  COMMAND_OFS    = 8'h04;
	localparam logic [7:0]  STATUS_OFS     = 8'h08;
	localparam logic [7:0]  IRQ_STATUS_OFS = 8'h0C;
	localparam logic [7:0]  IRQ_CLEAR_OFS  = 8'h10;
	localparam logic [7:0]  IRQ_ENABLE_OFS = 8'h14;
	localparam logic [7:0]  HOURS_OFS      = 8'h18;
	localparam logic [7:0]  SECONDS_OFS    = 8'h1C;

	// field positions
	localparam int unsigned CTRL_MAIN_SCREEN = 0;
	localparam int unsigned CMD_SCR_START    = 0;
	localparam int unsigned CMD_SCR_STOP     = 1;
	localparam int unsigned IRQ_W            = 5;
	localparam int unsigned IRQ_START        = 0;
	localparam int unsigned IRQ_STOP         = 1;
	localparam int unsigned IRQ_ERROR        = 2;
	localparam int unsigned IRQ_WARNING      = 3;
	localparam int unsigned IRQ_INHIBIT      = 4;

	// reset values
	localparam logic [31:0] CONTROL_RST    = 32'h0000_0000;
	localparam logic [31:0] IRQ_ENABLE_RST = 32'h0000_0000;

endpackage

// ### tb/compressor_remote_io_control_monitor.sv
// Purpose: port-level checks of the remote I/O control block
// Assumes: one pclk domain; presetn asynchronous, active low
// Notes:   held counters let a pin change pass sync and filter first
module compressor_remote_io_control_monitor #(
	parameter int unsigned FILTER     = 4,
	parameter int unsigned SEC_CYCLES = 10
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic remote_start_in,
	input wire logic remote_inhibit_in,
	input wire logic level_mode_select_in,
	input wire logic he_temp_high,
	input wire logic line_power_ok,
	input wire logic safety_trip_in,
	input wire logic compressor_run,
	input wire logic running_contact,
	input wire logic all_ok_contact,
	input wire logic over_temp_contact,
	input wire logic on_lamp,
	input wire logic off_lamp,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	// margin over the pin path; shorter holds may legally go unseen
	localparam int unsigned LAT = FILTER + 8;
	logic [4:0]  cond;
	logic [4:0]  held;
	int unsigned cnt_q [5];
	assign cond = {remote_inhibit_in, !line_power_ok, safety_trip_in, he_temp_high,
		level_mode_select_in & !remote_start_in};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt_q <= '{default: 0};
		else
			for (int i = 0; i < 5; i++)
				cnt_q[i] <= !cond[i] ? 0 : (cnt_q[i] < LAT ? cnt_q[i] + 1 : LAT);
	end
	always_comb begin
		for (int i = 0; i < 5; i++)
			held[i] = (cnt_q[i] == LAT);
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	property p_run_contact; running_contact == compressor_run; endproperty
	a_run_contact: assert property (p_run_contact) else $error("run contact off");
	property p_on_lamp; on_lamp == compressor_run; endproperty
	a_on_lamp: assert property (p_on_lamp) else $error("on lamp off");
	property p_inhibit; held[4] |-> !compressor_run; endproperty
	a_inhibit: assert property (p_inhibit) else $error("run under inhibit");
	property p_level; held[0] |-> !compressor_run; endproperty
	a_level: assert property (p_level) else $error("run with start low");
	property p_power; held[3] |-> !all_ok_contact; endproperty
	a_power: assert property (p_power) else $error("all ok without power");
	property p_trip; held[2] |-> off_lamp && !all_ok_contact; endproperty
	a_trip: assert property (p_trip) else $error("trip not shown");
	property p_temp; held[1] |-> over_temp_contact && !compressor_run; endproperty
	a_temp: assert property (p_temp) else $error("temp error not latched");
	property p_apb; psel && penable && !pready |=> pready ##1 !pready; endproperty
	a_apb: assert property (p_apb) else $error("bad ready timing");
	c_run: cover property ($rose(compressor_run));
	c_err: cover property (pready && pslverr);
	c_irq: cover property ($rose(irq));
endmodule

bind compressor_remote_io_control compressor_remote_io_control_monitor #(
	.FILTER(FILTER),
	.SEC_CYCLES(SEC_CYCLES)
) monitor_inst (
	.pclk, .presetn, .psel, .penable, .pready, .pslverr, .remote_start_in,
	.remote_inhibit_in, .level_mode_select_in, .he_temp_high, .line_power_ok,
	.safety_trip_in, .compressor_run, .running_contact, .all_ok_contact,
	.over_temp_contact, .on_lamp, .off_lamp, .irq
);

// ### tb/compressor_remote_io_control_tb.sv
// Purpose: self-checking bench for the remote I/O control block
// Assumes: shortened filter and second counts
// Notes:   pin effects get a settle time above the filter delay, SET cycles for misc pins and SET plus 0 to 3 for remote pins
module compressor_remote_io_control_tb
	import remote_io_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned FLT  = 4;
	localparam int unsigned SET  = FLT + 12;
	localparam logic [31:0] IDLE = 32'h0000_0202;
	localparam logic [31:0] RUN  = 32'h0000_0203;
	localparam logic [31:0] ALL  = 32'hFFFF_FFFF;
	localparam logic [31:0] NOFF = 32'hFFFF_FEFF;
	typedef struct packed {
		logic [31:0] val;
		logic [31:0] mask;
		logic        err;
	} note_type;
	note_type    notes [$];
	note_type    nt;
	logic        pclk     = 1'b0;
	logic        presetn  = 1'b0;
	logic [7:0]  paddr    = 8'h00;
	logic        psel     = 1'b0;
	logic        penable  = 1'b0;
	logic        pwrite   = 1'b0;
	logic [31:0] pwdata   = 32'h0;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	// buttons 0-2, temp, pressure, fault, warning, power, trip
	logic [8:0]  misc     = 9'h080;
	wire  [7:0]  outs;
	wire  [3:0]  rpin;
	int unsigned failures = 0;
	int unsigned compares = 0;
	int unsigned cycles   = 0;
	logic [31:0] r;
	logic [31:0] last;

	always #4 pclk = ~pclk;
	remote_controller_model #(.HOLD(SET)) remote_controller_model_inst (
		.pclk(pclk), .remote_start_in(rpin[0]), .remote_stop_in(rpin[1]),
		.remote_inhibit_in(rpin[2]), .level_mode_select_in(rpin[3]));
	compressor_remote_io_control #(.FILTER(FLT), .SEC_CYCLES(10)) compressor_remote_io_control_inst (
		.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr, .remote_start_in(rpin[0]), .remote_stop_in(rpin[1]),
		.remote_inhibit_in(rpin[2]), .level_mode_select_in(rpin[3]),
		.mech_start_btn(misc[0]), .mech_stop_btn(misc[1]), .panel_reset_btn(misc[2]),
		.he_temp_high(misc[3]), .he_pressure_high(misc[4]), .fault_in(misc[5]),
		.warning_in(misc[6]), .line_power_ok(misc[7]), .safety_trip_in(misc[8]),
		.compressor_run(outs[0]), .running_contact(outs[1]), .all_ok_contact(outs[2]),
		.over_temp_contact(outs[3]), .over_pressure_contact(outs[4]),
		.on_lamp(outs[5]), .off_lamp(outs[6]), .irq(outs[7]));

	task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic ck(input logic got, input logic exp);
		cmp({32'h0, got}, {32'h0, exp});
	endtask
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			nt = notes.pop_front();
			cmp({pslverr, prdata & nt.mask}, {nt.err, nt.val & nt.mask});
		end
	end
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
			input logic [31:0] e, input logic [31:0] m, input logic er);
		notes.push_back('{e, m, er});
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		last = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		apb(a, 1'b0, 32'h0, e, m, 1'b0);
	endtask
	task automatic st(input logic [31:0] e, input logic [31:0] m);
		rd(STATUS_OFS, e, m);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d, 32'h0, 32'h0, 1'b0);
		repeat (SET) @(posedge pclk);
	endtask
	task automatic rp(input int unsigned i);
		remote_controller_model_inst.pulse(i, $urandom_range(3));
	endtask
	task automatic rl(input int unsigned i, input logic v);
		remote_controller_model_inst.drive(i, v, $urandom_range(3));
	endtask
	task automatic mi(input int unsigned i, input logic v);
		misc[i] <= v;
		repeat (SET) @(posedge pclk);
	endtask
	task automatic tally_and_finish;
		if (failures == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			tally_and_finish;
		end
	end

	initial begin
		r = $urandom(27);
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (SET) @(posedge pclk);
		rd(CONTROL_OFS, CONTROL_RST, ALL);
		rd(IRQ_ENABLE_OFS, IRQ_ENABLE_RST, ALL);
		rd(SECONDS_OFS, 32'h0, ALL);
		apb(8'h40, 1'b0, 32'h0, 32'h0, ALL, 1'b1);
		wr(COMMAND_OFS, 32'h1);
		st(IDLE, ALL);
		wr(CONTROL_OFS, 32'h1);
		wr(COMMAND_OFS, 32'h1);
		st(RUN, ALL);
		wr(COMMAND_OFS, 32'h2);
		st(32'h302, ALL);
		mi(0, 1'b1);
		mi(0, 1'b0);
		st(RUN, ALL);
		mi(1, 1'b1);
		mi(1, 1'b0);
		st(32'h302, ALL);
		rp(0);
		st(RUN, ALL);
		rp(1);
		st(IDLE, NOFF);
		ck(outs[1], 1'b0);
		rp(0);
		rl(2, 1'b1);
		rp(0);
		st(32'h242, NOFF);
		rl(2, 1'b0);
		rl(3, 1'b1);
		rl(0, 1'b1);
		rp(1);
		st(32'h283, ALL);
		rl(0, 1'b0);
		st(32'h282, NOFF);
		rl(3, 1'b0);
		rp(0);
		mi(3, 1'b1);
		mi(3, 1'b0);
		st(32'h204, NOFF);
		mi(2, 1'b1);
		mi(2, 1'b0);
		st(IDLE, NOFF);
		ck(outs[3], 1'b0);
		mi(4, 1'b1);
		rp(1);
		mi(4, 1'b0);
		st(32'h208, NOFF);
		rp(1);
		ck(outs[4], 1'b0);
		mi(5, 1'b1);
		mi(5, 1'b0);
		st(32'h210, NOFF);
		wr(IRQ_CLEAR_OFS, 32'h1F);
		wr(IRQ_ENABLE_OFS, 32'h1);
		rp(0);
		st(RUN, ALL);
		ck(outs[7], 1'b1);
		wr(IRQ_ENABLE_OFS, 32'h0);
		ck(outs[7], 1'b0);
		wr(IRQ_ENABLE_OFS, 32'h1);
		wr(IRQ_CLEAR_OFS, 32'h1);
		ck(outs[7], 1'b0);
		r = $urandom;
		wr(IRQ_ENABLE_OFS, r);
		rd(IRQ_ENABLE_OFS, r, 32'h1F);
		rp(1);
		mi(6, 1'b1);
		st(32'h220, NOFF);
		mi(6, 1'b0);
		st(IDLE, NOFF);
		mi(7, 1'b0);
		st(32'h0, NOFF);
		mi(7, 1'b1);
		mi(8, 1'b1);
		rp(0);
		st(32'h700, ALL);
		mi(8, 1'b0);
		rd(SECONDS_OFS, 32'h0, 32'h0);
		r = last;
		repeat (40) @(posedge pclk);
		rd(SECONDS_OFS, r, ALL);
		rp(0);
		rp(1);
		rd(SECONDS_OFS, 32'h0, 32'h0);
		ck(last != r, 1'b1);
		wr(HOURS_OFS, ALL);
		rd(HOURS_OFS, 32'h0, ALL);
		tally_and_finish;
	end
endmodule

// ### tb/remote_controller_model.sv
// Purpose: remote controller on the contact inputs
// Assumes: true is 1; an open input reads 0
// Notes:   each level stands HOLD cycles plus a chosen extra
module remote_controller_model #(
	parameter int unsigned HOLD = 16
) (
	input  wire logic pclk,
	output logic      remote_start_in,
	output logic      remote_stop_in,
	output logic      remote_inhibit_in,
	output logic      level_mode_select_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] pin_q = 4'h0;
	assign {level_mode_select_in, remote_inhibit_in, remote_stop_in, remote_start_in} = pin_q;
	task automatic drive(input int unsigned i, input logic v, input int unsigned x);
		pin_q[i] <= v;
		repeat (HOLD + x) @(posedge pclk);
	endtask
	task automatic pulse(input int unsigned i, input int unsigned x);
		drive(i, 1'b1, x);
		drive(i, 1'b0, x);
	endtask
endmodule
